/* hw/clock_loss_detect.sv */
/*
 * Flags a receive clock that has shown no transition for the loss time.
 * Assumes the clock pin is sampled as an ordinary input synchronous to aclk.
 */
`include "rx_info_defines.svh"

module clock_loss_detect
    import rx_info_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic clk_sample, // Sampled receive clock pin
    output logic loss // High while the clock is stuck
);
    localparam logic [8:0] LOSS_LIMIT = 9'(`CLOCK_LOSS_CYCLES);

    logic prev;
    logic [8:0] quiet_cnt;
    logic [8:0] next_quiet_cnt;

    // Quiet cycles since the last edge, saturating
    always_comb begin
        if (clk_sample != prev) begin
            next_quiet_cnt = 9'h000;
        end else if (quiet_cnt != LOSS_LIMIT) begin
            next_quiet_cnt = quiet_cnt + 9'h001;
        end else begin
            next_quiet_cnt = quiet_cnt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 1'b0;
            quiet_cnt <= 9'h000;
            loss <= 1'b0;
        end else begin
            prev <= clk_sample;
            quiet_cnt <= next_quiet_cnt;
            loss <= (next_quiet_cnt == LOSS_LIMIT);
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_edge_clears_loss: assert property ((clk_sample != prev) |=> !loss)
        else $error("clock loss flag set despite an edge");
    a_loss_at_limit: assert property ((quiet_cnt == LOSS_LIMIT - 9'h001 && clk_sample == prev)
        |=> loss)
        else $error("clock loss flag late after quiet time");
    a_loss_needs_quiet: assert property (!loss ##1 loss |-> quiet_cnt == LOSS_LIMIT)
        else $error("clock loss flag set before quiet time");
    c_clock_lost: cover property (!loss ##1 loss);
endmodule

/* hw/rx_info_defines.svh */
/*
 * Constants of the receive information register bank: register indices,
 * field positions, reset values and timing counts.
 * Assumes an AXI4-Lite slave with 12-bit byte addresses, byte address = 4 x index.
 */
`ifndef RX_INFO_DEFINES_SVH
`define RX_INFO_DEFINES_SVH

// Register indices (byte address is four times the index)
`define CTRL_IDX 10'h000
`define RX_INFO3_A_IDX 10'h010
`define RX_INFO3_B_IDX 10'h0B0
`define RX_INFO2_B_IDX 10'h0D1

// Control register
`define CTRL_RESET 8'h00
`define CTRL_JA_LONG_BIT 0

// Second information register, framer B
`define SYNC_REGAINED_BIT 7
`define CARRIER_RESTORED_BIT 5
`define AIS_CLEARED_BIT 2

// Third information registers
`define LEVEL_HI_BIT 7
`define LEVEL_LO_BIT 6
`define JITTER_LIMIT_BIT 5
`define CLOCK_LOSS_BIT 4
`define LINE_CARRIER_BIT 3
`define AIS_CI_BIT 0

// Jitter attenuator depths and warning margin, in bits
`define JA_DEPTH_SHORT 8'h20
`define JA_DEPTH_LONG 8'h80
`define JA_LIMIT_MARGIN 8'h04

// Receive level thresholds in half-dB of attenuation: 7.5, 15, 22.5 dB
`define LEVEL_STEP1_HALFDB 8'h0F
`define LEVEL_STEP2_HALFDB 8'h1E
`define LEVEL_STEP3_HALFDB 8'h2D

// Receive clock loss time and derived cycle count (least time, rounded up)
`define CLK_PERIOD_PS 4000
`define CLOCK_LOSS_TIME_US 2
`define CLOCK_LOSS_CYCLES ((`CLOCK_LOSS_TIME_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* hw/rx_info_pkg.sv */
/*
 * Types of the receive information register bank.
 * Assumes nothing beyond the constants header.
 */
package rx_info_pkg;
    // Read channel sequencing
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_t;

    // Index of the framer-B events that latch until read
    typedef enum logic [1:0] {
        EV_SYNC = 2'b00,
        EV_CARRIER = 2'b01,
        EV_AIS = 2'b10
    } latch_event_t;
endpackage

/* hw/t1_rx_alarm_info_regs.sv */
/*
 * Receive information registers of a dual T1 framer, reached over AXI4-Lite.
 * Assumes framer status inputs are levels synchronous to aclk and that the
 * receive clock pins are sampled as ordinary inputs.
 */
// Local design decision: the AXI4-Lite slave port.
`include "rx_info_defines.svh"

module t1_rx_alarm_info_regs
    import rx_info_pkg::*;
(
    input wire logic aclk, // System clock, 250 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] awaddr, // Write address
    input wire logic [2:0] awprot, // Write protection, unused
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [11:0] araddr, // Read address
    input wire logic [2:0] arprot, // Read protection, unused
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic in_sync_b, // Framer B synchronized
    input wire logic carrier_loss_b, // Framer B receive carrier lost
    input wire logic blue_alarm_status_a, // Framer A unframed all-ones seen
    input wire logic blue_alarm_status_b, // Framer B unframed all-ones seen
    input wire logic ais_ci_pattern_a, // Framer A AIS-CI pattern seen
    input wire logic ais_ci_pattern_b, // Framer B AIS-CI pattern seen
    input wire logic rx_clock_in_a, // Framer A receive clock pin
    input wire logic rx_clock_in_b, // Framer B receive clock pin
    input wire logic [7:0] rx_atten_halfdb, // Received loss, half-dB steps
    input wire logic [7:0] ja_fill, // Jitter attenuator FIFO fill, bits
    input wire logic line_carrier_loss_in // Line interface carrier loss
);
    logic [7:0] ctrl;
    logic aw_held;
    logic w_held;
    logic [9:0] aw_idx;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    rd_state_t rd_state;
    logic rd_is_info2b;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [2:0] prev_status;
    logic [2:0] latch_event;
    logic [2:0] latch_clear;
    logic [2:0] latch_flag;
    logic rx_level_code_hi;
    logic rx_level_code_lo;
    logic jitter_fifo_limit_flag;
    logic line_carrier_loss_flag;
    logic [1:0] ais_ci_detect_flag;
    logic [1:0] rx_clock_loss_flag;
    logic [1:0] rx_clock_pins;
    logic [1:0] blue_pins;
    logic [1:0] ais_ci_pins;
    logic [7:0] ja_limit;
    logic [7:0] info2b;
    logic [7:0] info3a;
    logic [7:0] info3b;

    // Write channel handshakes; address and data taken in either order
    assign wr_fire = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b0;
            aw_idx <= 10'h000;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            aw_idx <= awaddr[11:2];
        end else begin
            aw_held <= aw_held && !wr_fire;
            awready <= !(aw_held && !wr_fire);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            wready <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else begin
            w_held <= w_held && !wr_fire;
            wready <= !(w_held && !wr_fire);
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            case (aw_idx)
                `CTRL_IDX, `RX_INFO3_A_IDX, `RX_INFO3_B_IDX, `RX_INFO2_B_IDX: begin
                    bresp <= `RESP_OKAY;
                end
                default: begin
                    bresp <= `RESP_SLVERR;
                end
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control register; information registers ignore writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CTRL_RESET;
        end else if (wr_fire && aw_idx == `CTRL_IDX && wstrb_q[0]) begin
            ctrl <= wdata_q[7:0];
        end
    end

    assign ja_limit = ctrl[`CTRL_JA_LONG_BIT] ? `JA_DEPTH_LONG : `JA_DEPTH_SHORT;

    // Edge sources for framer-B latched events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_status <= 3'b000;
        end else begin
            prev_status[EV_SYNC] <= in_sync_b;
            prev_status[EV_CARRIER] <= carrier_loss_b;
            prev_status[EV_AIS] <= blue_alarm_status_b;
        end
    end

    assign latch_event[EV_SYNC] = in_sync_b && !prev_status[EV_SYNC];
    assign latch_event[EV_CARRIER] = !carrier_loss_b && prev_status[EV_CARRIER];
    assign latch_event[EV_AIS] = !blue_alarm_status_b && prev_status[EV_AIS];

    // only reported bits clear on completed read
    assign latch_clear[EV_SYNC] = rvalid && rready && rd_is_info2b
        && rdata[`SYNC_REGAINED_BIT];
    assign latch_clear[EV_CARRIER] = rvalid && rready && rd_is_info2b
        && rdata[`CARRIER_RESTORED_BIT];
    assign latch_clear[EV_AIS] = rvalid && rready && rd_is_info2b
        && rdata[`AIS_CLEARED_BIT];

    for (genvar i = 0; i < 3; i++) begin : g_latch
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                latch_flag[i] <= 1'b0;
            end else begin
                latch_flag[i] <= latch_event[i] || (latch_flag[i] && !latch_clear[i]);
            end
        end
    end

    // Framer A level, jitter and line carrier status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_level_code_hi <= 1'b0;
            rx_level_code_lo <= 1'b0;
            jitter_fifo_limit_flag <= 1'b0;
            line_carrier_loss_flag <= 1'b0;
        end else begin
            rx_level_code_hi <= rx_atten_halfdb >= `LEVEL_STEP2_HALFDB;
            rx_level_code_lo <= (rx_atten_halfdb >= `LEVEL_STEP1_HALFDB
                && rx_atten_halfdb < `LEVEL_STEP2_HALFDB)
                || rx_atten_halfdb >= `LEVEL_STEP3_HALFDB;
            jitter_fifo_limit_flag <= ja_fill >= ja_limit - `JA_LIMIT_MARGIN;
            line_carrier_loss_flag <= line_carrier_loss_in;
        end
    end

    // Per-framer clock loss and AIS-CI
    assign rx_clock_pins = {rx_clock_in_b, rx_clock_in_a};
    assign blue_pins = {blue_alarm_status_b, blue_alarm_status_a};
    assign ais_ci_pins = {ais_ci_pattern_b, ais_ci_pattern_a};

    for (genvar f = 0; f < 2; f++) begin : g_framer
        clock_loss_detect u_loss (
            .aclk(aclk),
            .aresetn(aresetn),
            .clk_sample(rx_clock_pins[f]),
            .loss(rx_clock_loss_flag[f])
        );

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ais_ci_detect_flag[f] <= 1'b0;
            end else begin
                ais_ci_detect_flag[f] <= ais_ci_pins[f] && blue_pins[f];
            end
        end
    end

    always_comb begin
        info2b = 8'h00;
        info2b[`SYNC_REGAINED_BIT] = latch_flag[EV_SYNC];
        info2b[`CARRIER_RESTORED_BIT] = latch_flag[EV_CARRIER];
        info2b[`AIS_CLEARED_BIT] = latch_flag[EV_AIS];
        info3a = 8'h00;
        // upper code bit at bit 7
        info3a[`LEVEL_HI_BIT] = rx_level_code_hi;
        info3a[`LEVEL_LO_BIT] = rx_level_code_lo;
        info3a[`JITTER_LIMIT_BIT] = jitter_fifo_limit_flag;
        info3a[`CLOCK_LOSS_BIT] = rx_clock_loss_flag[0];
        info3a[`LINE_CARRIER_BIT] = line_carrier_loss_flag;
        info3a[`AIS_CI_BIT] = ais_ci_detect_flag[0];
        info3b = 8'h00;
        info3b[`CLOCK_LOSS_BIT] = rx_clock_loss_flag[1];
        info3b[`AIS_CI_BIT] = ais_ci_detect_flag[1];
    end

    // Read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b1;
        unique case (araddr[11:2])
            `CTRL_IDX: rd_word[7:0] = ctrl;
            `RX_INFO3_A_IDX: rd_word[7:0] = info3a;
            `RX_INFO3_B_IDX: rd_word[7:0] = info3b;
            `RX_INFO2_B_IDX: rd_word[7:0] = info2b;
            default: rd_ok = 1'b0;
        endcase
    end

    // Read channel: data captured when the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state <= RD_IDLE;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
            rd_is_info2b <= 1'b0;
        end else begin
            unique case (rd_state)
                RD_IDLE: begin
                    arready <= 1'b1;
                    if (arvalid && arready) begin
                        rd_state <= RD_RESP;
                        arready <= 1'b0;
                        rvalid <= 1'b1;
                        rdata <= rd_word;
                        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
                        rd_is_info2b <= araddr[11:2] == `RX_INFO2_B_IDX;
                    end
                end
                RD_RESP: begin
                    if (rready) begin
                        rd_state <= RD_IDLE;
                        rvalid <= 1'b0;
                        arready <= 1'b1;
                        rd_is_info2b <= 1'b0;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sync_regained_set: assert property (latch_event[EV_SYNC] |=> latch_flag[EV_SYNC])
        else $error("sync regained flag not set");
    a_carrier_restored_set: assert property ($fell(carrier_loss_b)
        |=> latch_flag[EV_CARRIER])
        else $error("carrier restored flag not set");
    a_ais_cleared_set: assert property ($fell(blue_alarm_status_b)
        |=> latch_flag[EV_AIS])
        else $error("AIS cleared flag not set");
    a_unassigned_zero: assert property (rvalid && rd_is_info2b
        |-> rdata[6] == 1'b0 && rdata[4:3] == 2'b00 && rdata[1:0] == 2'b00)
        else $error("unassigned bits not zero");
    a_jitter_near_limit: assert property (##1 jitter_fifo_limit_flag
        == (9'($past(ja_fill)) + 9'(`JA_LIMIT_MARGIN) >= 9'($past(ja_limit))))
        else $error("jitter limit flag wrong");
    a_level_bit_order: assert property (rvalid && rdata[7:6] == 2'b11
        && $past(arvalid && arready) && $past(araddr[11:2]) == `RX_INFO3_A_IDX
        |-> $past(rx_level_code_hi && rx_level_code_lo))
        else $error("level code bits misplaced");
    a_level_code_map: assert property ($past(rx_atten_halfdb) >= `LEVEL_STEP3_HALFDB
        |-> rx_level_code_hi && rx_level_code_lo)
        else $error("level code for deep loss wrong");
    a_level_code_low: assert property ($past(rx_atten_halfdb) < `LEVEL_STEP1_HALFDB
        |-> !rx_level_code_hi && !rx_level_code_lo)
        else $error("level code for strong signal wrong");
    a_ais_ci_qualified: assert property (ais_ci_detect_flag[0]
        |-> $past(blue_alarm_status_a))
        else $error("AIS-CI flag without blue alarm");
    a_flag_holds_read: assert property (latch_flag[EV_SYNC] && !latch_clear[EV_SYNC]
        |=> latch_flag[EV_SYNC])
        else $error("sync regained flag lost without read");
    a_event_beats_clear: assert property (latch_clear[EV_AIS] && latch_event[EV_AIS]
        |=> latch_flag[EV_AIS])
        else $error("AIS cleared event lost at read");

    c_read_clears: cover property (latch_flag[EV_SYNC] && latch_clear[EV_SYNC]
        ##1 !latch_flag[EV_SYNC]);
    c_ctrl_write: cover property (wr_fire && aw_idx == `CTRL_IDX);
    c_ais_ci_seen: cover property (ais_ci_detect_flag[1]);
endmodule

/* tb/axil_host.sv */
/*
 * Host model on the register bus: AXI4-Lite master with one write and one read task.
 * Assumes the slave samples on the rising edge of aclk and holds answers until taken.
 */
module axil_host (
    input wire logic aclk, // System clock
    output logic [11:0] awaddr, // Write address
    output logic [2:0] awprot, // Write protection
    output logic awvalid, // Write address valid
    input wire logic awready, // Write address ready
    output logic [31:0] wdata, // Write data
    output logic [3:0] wstrb, // Byte strobes
    output logic wvalid, // Write data valid
    input wire logic wready, // Write data ready
    input wire logic [1:0] bresp, // Write response
    input wire logic bvalid, // Write response valid
    output logic bready, // Write response ready
    output logic [11:0] araddr, // Read address
    output logic [2:0] arprot, // Read protection
    output logic arvalid, // Read address valid
    input wire logic arready, // Read address ready
    input wire logic [31:0] rdata, // Read data
    input wire logic [1:0] rresp, // Read response
    input wire logic rvalid, // Read data valid
    output logic rready // Read data ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus from time zero
    initial begin
        {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arprot, arvalid, rready} = '0;
    end

    // Address and data offered together, each dropped at its own take
    task automatic write(input logic [11:0] addr, input logic [31:0] data,
                         output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= addr;
        awvalid <= 1'b1;
        wdata <= data;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_done && w_done));
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Ready held from the start, so the answer is taken at first sight
    task automatic read(input logic [11:0] addr, output logic [31:0] data,
                        output logic [1:0] resp);
        @(posedge aclk);
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule

/* tb/t1_rx_alarm_info_regs_bench.sv */
/*
 * Self-checking bench of the receive information register bank.
 * Assumes the host model in axil_host and the constants header on the include path.
 */
`include "rx_info_defines.svh"

module t1_rx_alarm_info_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import rx_info_pkg::*;

    localparam logic [11:0] CTRL_A = {`CTRL_IDX, 2'b00};
    localparam logic [11:0] I3A_A = {`RX_INFO3_A_IDX, 2'b00};
    localparam logic [11:0] I3B_A = {`RX_INFO3_B_IDX, 2'b00};
    localparam logic [11:0] I2B_A = {`RX_INFO2_B_IDX, 2'b00};

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic in_sync_b, carrier_loss_b, blue_a, blue_b, pat_a, pat_b;
    logic clk_in_a, clk_in_b, run_a, run_b, line_loss;
    logic [7:0] atten, ja_fill;
    int bad_count, num_checks, cycles;

    axil_host u_host (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    t1_rx_alarm_info_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .in_sync_b(in_sync_b), .carrier_loss_b(carrier_loss_b),
        .blue_alarm_status_a(blue_a), .blue_alarm_status_b(blue_b),
        .ais_ci_pattern_a(pat_a), .ais_ci_pattern_b(pat_b), .rx_clock_in_a(clk_in_a),
        .rx_clock_in_b(clk_in_b), .rx_atten_halfdb(atten), .ja_fill(ja_fill),
        .line_carrier_loss_in(line_loss));

    // 250 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Receive clock pins toggle while their framer is running
    always @(posedge aclk) begin
        if (run_a) clk_in_a <= ~clk_in_a;
        if (run_b) clk_in_b <= ~clk_in_b;
    end

    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_chk(input string name, input logic [11:0] addr, input logic [7:0] mask,
                          input logic [7:0] exp, input logic [1:0] exp_resp);
        logic [31:0] data;
        logic [1:0] resp;
        u_host.read(addr, data, resp);
        check(name, {24'h0, data[7:0] & mask}, {24'h0, exp});
        check({name, " resp"}, {30'h0, resp}, {30'h0, exp_resp});
    endtask

    task automatic wr_chk(input string name, input logic [11:0] addr, input logic [31:0] data,
                          input logic [1:0] exp_resp);
        logic [1:0] resp;
        u_host.write(addr, data, resp);
        check(name, {30'h0, resp}, {30'h0, exp_resp});
    endtask

    task automatic settle();
        repeat (3) @(posedge aclk);
    endtask

    // Flags clear after reset, each latch sets its own bit and clears on read
    task automatic test_latches();
        rd_chk("info2 b reset", I2B_A, 8'hA4, 8'h00, `RESP_OKAY);
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk);
            if (i == 0) in_sync_b <= 1'b1;
            if (i == 1) carrier_loss_b <= 1'b0;
            if (i == 2) blue_b <= 1'b0;
            settle();
            rd_chk("info3 b no clear", I3B_A, 8'h11, 8'h00, `RESP_OKAY);
            rd_chk("info2 b set", I2B_A, 8'hA4, (i == 0) ? 8'h80 : (i == 1) ? 8'h20 : 8'h04,
                   `RESP_OKAY);
            rd_chk("info2 b cleared", I2B_A, 8'hA4, 8'h00, `RESP_OKAY);
            @(posedge aclk);
            in_sync_b <= 1'b0;
            carrier_loss_b <= 1'b1;
            blue_b <= 1'b1;
            settle();
        end
        @(posedge aclk);
        in_sync_b <= 1'b1;
        settle();
        @(posedge aclk);
        in_sync_b <= 1'b0;
        fork
            rd_chk("info2 b race", I2B_A, 8'hA4, 8'h80, `RESP_OKAY);
            begin
                @(posedge aclk iff (arvalid && arready));
                in_sync_b <= 1'b1;
            end
        join
        rd_chk("info2 b kept", I2B_A, 8'hA4, 8'h80, `RESP_OKAY);
        rd_chk("info2 b gone", I2B_A, 8'hA4, 8'h00, `RESP_OKAY);
    endtask

    // Level code boundaries at 15, 30 and 45 half-dB
    task automatic test_level();
        logic [7:0] vals [8] = '{8'h00, 8'h0E, 8'h0F, 8'h1D, 8'h1E, 8'h2C, 8'h2D, 8'hFF};
        logic [1:0] codes [8] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3};
        for (int i = 0; i < 8; i++) begin
            @(posedge aclk);
            atten <= vals[i];
            settle();
            rd_chk("level code", I3A_A, 8'hC0, {codes[i], 6'h00}, `RESP_OKAY);
        end
    endtask

    // Limit flag four bits short of each selectable depth
    task automatic test_jitter();
        logic [7:0] fills [4] = '{8'd27, 8'd28, 8'd123, 8'd124};
        for (int i = 0; i < 4; i++) begin
            wr_chk("ctrl write", CTRL_A, {31'h0, i[1]}, `RESP_OKAY);
            rd_chk("ctrl readback", CTRL_A, 8'h01, {7'h00, i[1]}, `RESP_OKAY);
            @(posedge aclk);
            ja_fill <= fills[i];
            settle();
            rd_chk("jitter flag", I3A_A, 8'h20, i[0] ? 8'h20 : 8'h00, `RESP_OKAY);
        end
        @(posedge aclk);
        ja_fill <= 8'h00;
    endtask

    // Quiet receive clock for under and over the 500-cycle loss time
    task automatic test_clock_loss();
        for (int j = 0; j < 2; j++) begin
            @(posedge aclk);
            if (j == 0) run_a <= 1'b0;
            else run_b <= 1'b0;
            repeat (400) @(posedge aclk);
            rd_chk("loss early", j ? I3B_A : I3A_A, 8'h10, 8'h00, `RESP_OKAY);
            repeat (150) @(posedge aclk);
            rd_chk("loss a", I3A_A, 8'h10, j ? 8'h00 : 8'h10, `RESP_OKAY);
            rd_chk("loss b", I3B_A, 8'h10, j ? 8'h10 : 8'h00, `RESP_OKAY);
            @(posedge aclk);
            run_a <= 1'b1;
            run_b <= 1'b1;
            settle();
            rd_chk("loss gone", j ? I3B_A : I3A_A, 8'h10, 8'h00, `RESP_OKAY);
        end
    endtask

    // AIS-CI qualified by blue alarm; line carrier loss rides along
    task automatic test_ais_ci();
        for (int k = 0; k < 4; k++) begin
            @(posedge aclk);
            pat_a <= k[0];
            pat_b <= k[0];
            blue_a <= k[1];
            blue_b <= k[1];
            line_loss <= k[0];
            settle();
            rd_chk("ais-ci a", I3A_A, 8'h09, {4'h0, k[0], 2'b00, k == 3}, `RESP_OKAY);
            rd_chk("ais-ci b", I3B_A, 8'h01, {7'h00, k == 3}, `RESP_OKAY);
        end
        // Blue alarm of framer B fell at the first step
        rd_chk("ais gone b", I2B_A, 8'hA4, 8'h04, `RESP_OKAY);
    endtask

    // Unmapped places refused, info registers ignore writes
    task automatic test_bus();
        rd_chk("unmapped read", 12'h004, 8'hFF, 8'h00, `RESP_SLVERR);
        wr_chk("unmapped write", 12'h004, 32'h0000_00FF, `RESP_SLVERR);
        wr_chk("info write", I2B_A, 32'h0000_00FF, `RESP_OKAY);
        rd_chk("info2 b unwritten", I2B_A, 8'hA4, 8'h00, `RESP_OKAY);
    endtask

    initial begin
        {in_sync_b, pat_a, pat_b, clk_in_a, clk_in_b, line_loss} = '0;
        {carrier_loss_b, blue_a, blue_b, run_a, run_b} = '1;
        atten = 8'h00;
        ja_fill = 8'h00;
        bad_count = 0;
        num_checks = 0;
        cycles = 0;
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        test_latches();
        test_level();
        test_jitter();
        test_clock_loss();
        test_ais_ci();
        test_bus();
        stop_test();
    end
endmodule
